// *** common/jtc_pkg.sv ***
package jtc_pkg;
    localparam int IR_LEN = 10;
    localparam int ID_LEN = 32;
    localparam int CFG_LEN = 32;
    localparam int BSR_LEN = 12;
    localparam int TLR_ONES = 5;
    // Capture pattern; low two bits fixed at 01
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h011;
    // Opcodes arbitrary; only bypass all-ones is conventional
    localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h3c0;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h3c1;
    localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h3c9;
    localparam logic [IR_LEN-1:0] OP_CFG = 10'h3c5;
    localparam logic [IR_LEN-1:0] OP_SELFTEST = 10'h3c7;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3ff;
    localparam logic [IR_LEN-1:0] IR_RESET = OP_IDCODE;
    // Identity value arbitrary
    localparam logic [ID_LEN-1:0] ID_VALUE = 32'h0000_0001;
    localparam logic [CFG_LEN-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [BSR_LEN-1:0] BSR_RESET = 12'h000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jtc_state_t;

    typedef enum logic [2:0] {
        SEL_BYP, SEL_ID, SEL_CFG, SEL_BSR
    } jtc_dr_sel_t;
endpackage

// *** common/jtc_pins_if.sv ***
`timescale 1ns/1ns
interface jtc_pins_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    modport sync (output tck_rise, output tck_fall, output tms, output tdi);
    modport core (input tck_rise, input tck_fall, input tms, input tdi);
endinterface

// *** src/jtc_pin_sync.sv ***
`timescale 1ns/1ns
module jtc_pin_sync (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    jtc_pins_if.sync pins
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic tck_q;
    logic tms_q;
    logic tdi_q;

    // Third stage agreeing with second marks a settled change
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 3'h6;
            s2_q <= 3'h6;
            s3_q <= 3'h6;
        end else begin
            s1_q <= {tms, tdi, tck};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b1;
        end else begin
            if (s2_q[0] == s3_q[0]) begin
                tck_q <= s3_q[0];
            end
            if (s2_q[1] == s3_q[1]) begin
                tdi_q <= s3_q[1];
            end
            if (s2_q[2] == s3_q[2]) begin
                tms_q <= s3_q[2];
            end
        end
    end

    assign pins.tck_rise = (s2_q[0] == s3_q[0]) && s3_q[0] && !tck_q;
    assign pins.tck_fall = (s2_q[0] == s3_q[0]) && !s3_q[0] && tck_q;
    // TMS/TDI settle well before TCK rises, so the filtered value is current
    assign pins.tms = tms_q;
    assign pins.tdi = tdi_q;
endmodule

// *** src/jtc_tap.sv ***
`timescale 1ns/1ns
// Function
// - Sixteen-state controller with separate instruction and data scan paths.
// - Serial input sampled into selected register on each rising test clock while shifting.
// - Input and output register chosen by state and current instruction.
// - Output changes on falling edges; driven only during shifting.
// - State changes only on rising edges, steered by sampled mode-select.
// - Reset state disables all test logic for normal operation.
// - Five rising edges with mode-select high reach reset from anywhere.
// - No dedicated test reset pin; only mode-select sequence or power-up.
// - Run-idle activates test logic only when instruction demands it.
// - Select-data: low enters data path, high goes to select-instruction.
// - Select-instruction: low enters instruction path, high returns to reset.
// - Capture-instruction loads fixed pattern ending in 01.
// - Shift-instruction shifts captured pattern out and new instruction in.
// - Exit1-instruction: low to pause, high to update.
// - Pause-instruction holds the shift register unchanged.
// - Exit2-instruction: low back to shift, high to update.
// - Update-instruction latches on falling edge; becomes current instruction.
// - Data and instruction paths each have seven alike states.
// - Boundary-scan, bypass, instruction register and decoder present.
// - 32-bit identification register and configuration register selectable.
// - Capture-data loads the register selected by current instruction.
// - Instruction scan shifts least significant bit first.
// - Instruction register is ten bits wide.
// - Power-up resets controller; reprogram input does not.
module jtc_tap (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic program_n,
    input wire logic [jtc_pkg::BSR_LEN-1:0] bsr_pins_in,
    input wire logic [jtc_pkg::CFG_LEN-1:0] cfg_status_in,
    output logic tdo,
    output logic tdo_oe,
    output logic test_mode,
    output logic selftest_run,
    output logic [jtc_pkg::BSR_LEN-1:0] bsr_update,
    output logic [jtc_pkg::CFG_LEN-1:0] cfg_update,
    output logic [jtc_pkg::IR_LEN-1:0] cur_instr,
    output logic [3:0] tap_state
);
    jtc_pins_if pins();

    jtc_pin_sync u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .pins(pins)
    );

    jtc_pkg::jtc_state_t state_q;
    jtc_pkg::jtc_state_t state_d;
    jtc_pkg::jtc_dr_sel_t dr_sel;
    logic [jtc_pkg::IR_LEN-1:0] ir_sh_q;
    logic [jtc_pkg::IR_LEN-1:0] ir_q;
    logic byp_q;
    logic [jtc_pkg::ID_LEN-1:0] id_sh_q;
    logic [jtc_pkg::CFG_LEN-1:0] cfg_sh_q;
    logic [jtc_pkg::CFG_LEN-1:0] cfg_q;
    logic [jtc_pkg::BSR_LEN-1:0] bsr_sh_q;
    logic [jtc_pkg::BSR_LEN-1:0] bsr_q;
    logic tdo_q;
    logic tdo_oe_q;
    logic sel_out;
    logic shifting;

    // Program input deliberately unused: it must not reset the controller
    logic unused_program;
    assign unused_program = program_n;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            jtc_pkg::TLR: state_d = pins.tms ? jtc_pkg::TLR : jtc_pkg::RTI;
            jtc_pkg::RTI: state_d = pins.tms ? jtc_pkg::SEL_DR : jtc_pkg::RTI;
            jtc_pkg::SEL_DR: state_d = pins.tms ? jtc_pkg::SEL_IR : jtc_pkg::CAP_DR;
            jtc_pkg::CAP_DR: state_d = pins.tms ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR;
            jtc_pkg::SH_DR: state_d = pins.tms ? jtc_pkg::EX1_DR : jtc_pkg::SH_DR;
            jtc_pkg::EX1_DR: state_d = pins.tms ? jtc_pkg::UPD_DR : jtc_pkg::PAU_DR;
            jtc_pkg::PAU_DR: state_d = pins.tms ? jtc_pkg::EX2_DR : jtc_pkg::PAU_DR;
            jtc_pkg::EX2_DR: state_d = pins.tms ? jtc_pkg::UPD_DR : jtc_pkg::SH_DR;
            jtc_pkg::UPD_DR: state_d = pins.tms ? jtc_pkg::SEL_DR : jtc_pkg::RTI;
            jtc_pkg::SEL_IR: state_d = pins.tms ? jtc_pkg::TLR : jtc_pkg::CAP_IR;
            jtc_pkg::CAP_IR: state_d = pins.tms ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR;
            jtc_pkg::SH_IR: state_d = pins.tms ? jtc_pkg::EX1_IR : jtc_pkg::SH_IR;
            jtc_pkg::EX1_IR: state_d = pins.tms ? jtc_pkg::UPD_IR : jtc_pkg::PAU_IR;
            jtc_pkg::PAU_IR: state_d = pins.tms ? jtc_pkg::EX2_IR : jtc_pkg::PAU_IR;
            jtc_pkg::EX2_IR: state_d = pins.tms ? jtc_pkg::UPD_IR : jtc_pkg::SH_IR;
            jtc_pkg::UPD_IR: state_d = pins.tms ? jtc_pkg::SEL_DR : jtc_pkg::RTI;
        endcase
    end

    // Power-up reset only; five TMS-high edges land in TLR from any state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= jtc_pkg::TLR;
        end else if (pins.tck_rise) begin
            state_q <= state_d;
        end
    end

    // Decoder; unknown opcodes select bypass
    always_comb begin
        unique case (ir_q)
            jtc_pkg::OP_IDCODE: dr_sel = jtc_pkg::SEL_ID;
            jtc_pkg::OP_CFG: dr_sel = jtc_pkg::SEL_CFG;
            jtc_pkg::OP_EXTEST: dr_sel = jtc_pkg::SEL_BSR;
            jtc_pkg::OP_SAMPLE: dr_sel = jtc_pkg::SEL_BSR;
            default: dr_sel = jtc_pkg::SEL_BYP;
        endcase
    end

    // Instruction shift stages, LSB out first
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_sh_q <= jtc_pkg::IR_CAPTURE;
        end else if (pins.tck_rise) begin
            if (state_q == jtc_pkg::CAP_IR) begin
                ir_sh_q <= jtc_pkg::IR_CAPTURE;
            end else if (state_q == jtc_pkg::SH_IR) begin
                ir_sh_q <= {pins.tdi, ir_sh_q[jtc_pkg::IR_LEN-1:1]};
            end
            // Pause and exits leave the stages untouched
        end
    end

    // Instruction latch bank; TLR forces the reset instruction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_q <= jtc_pkg::IR_RESET;
        end else if (state_q == jtc_pkg::TLR) begin
            ir_q <= jtc_pkg::IR_RESET;
        end else if (pins.tck_fall && state_q == jtc_pkg::UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // Data registers: capture and shift gated by the decoder selection
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_q <= 1'b0;
            id_sh_q <= jtc_pkg::ID_VALUE;
            cfg_sh_q <= jtc_pkg::CFG_RESET;
            bsr_sh_q <= jtc_pkg::BSR_RESET;
        end else if (pins.tck_rise) begin
            if (state_q == jtc_pkg::CAP_DR) begin
                unique case (dr_sel)
                    jtc_pkg::SEL_BYP: byp_q <= 1'b0;
                    jtc_pkg::SEL_ID: id_sh_q <= jtc_pkg::ID_VALUE;
                    jtc_pkg::SEL_CFG: cfg_sh_q <= cfg_status_in;
                    jtc_pkg::SEL_BSR: bsr_sh_q <= bsr_pins_in;
                    default: byp_q <= 1'b0;
                endcase
            end else if (state_q == jtc_pkg::SH_DR) begin
                unique case (dr_sel)
                    jtc_pkg::SEL_BYP: byp_q <= pins.tdi;
                    jtc_pkg::SEL_ID: id_sh_q <= {pins.tdi, id_sh_q[jtc_pkg::ID_LEN-1:1]};
                    jtc_pkg::SEL_CFG: cfg_sh_q <= {pins.tdi, cfg_sh_q[jtc_pkg::CFG_LEN-1:1]};
                    jtc_pkg::SEL_BSR: bsr_sh_q <= {pins.tdi, bsr_sh_q[jtc_pkg::BSR_LEN-1:1]};
                    default: byp_q <= pins.tdi;
                endcase
            end
        end
    end

    // Update latches open on the falling edge in update-data
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bsr_q <= jtc_pkg::BSR_RESET;
            cfg_q <= jtc_pkg::CFG_RESET;
        end else if (state_q == jtc_pkg::TLR) begin
            bsr_q <= jtc_pkg::BSR_RESET;
        end else if (pins.tck_fall && state_q == jtc_pkg::UPD_DR) begin
            if (dr_sel == jtc_pkg::SEL_BSR) begin
                bsr_q <= bsr_sh_q;
            end
            if (dr_sel == jtc_pkg::SEL_CFG) begin
                cfg_q <= cfg_sh_q;
            end
        end
    end

    // Output mux by state and instruction
    always_comb begin
        sel_out = byp_q;
        if (state_q == jtc_pkg::SH_IR) begin
            sel_out = ir_sh_q[0];
        end else begin
            unique case (dr_sel)
                jtc_pkg::SEL_ID: sel_out = id_sh_q[0];
                jtc_pkg::SEL_CFG: sel_out = cfg_sh_q[0];
                jtc_pkg::SEL_BSR: sel_out = bsr_sh_q[0];
                default: sel_out = byp_q;
            endcase
        end
    end

    assign shifting = (state_q == jtc_pkg::SH_IR) || (state_q == jtc_pkg::SH_DR);

    // Retimed on falling edge so the master samples a stable bit on its rise
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (pins.tck_fall) begin
            // Released line holds its last bit rather than toggling
            if (shifting) begin
                tdo_q <= sel_out;
            end
            tdo_oe_q <= shifting;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;
    assign test_mode = (state_q != jtc_pkg::TLR) && (ir_q == jtc_pkg::OP_EXTEST);
    assign selftest_run = (state_q == jtc_pkg::RTI) && (ir_q == jtc_pkg::OP_SELFTEST);
    assign bsr_update = bsr_q;
    assign cfg_update = cfg_q;
    assign cur_instr = ir_q;
    assign tap_state = state_q;
endmodule

// *** bench/jtc_tap_checker.sv ***
`timescale 1ns/1ns
module jtc_tap_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic test_mode,
    input wire logic selftest_run,
    input wire logic [jtc_pkg::BSR_LEN-1:0] bsr_update,
    input wire logic [jtc_pkg::IR_LEN-1:0] cur_instr,
    input wire logic [3:0] tap_state
);
    // Next-state nibbles per state, for mode-select low and high
    localparam logic [63:0] N0 = 64'h1bddbba146644311;
    localparam logic [63:0] N1 = 64'h2fefcc0287855920;
    wire sh = tap_state == 4'h4 || tap_state == 4'hb;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_state_step: assert property ($changed(tap_state) |->
        tap_state == N0[4*$past(tap_state)+:4] || tap_state == N1[4*$past(tap_state)+:4])
        else $error("illegal state step");
    a_oe_in_shift: assert property ($rose(tdo_oe) |-> sh) else $error("output enabled outside shift");
    a_oe_drops: assert property (!sh [*8] |=> !tdo_oe) else $error("output enable stuck");
    a_tdo_quiet: assert property ($changed(tdo) |-> tdo_oe || $past(tdo_oe))
        else $error("tdo moved while released");
    a_reset_idcode: assert property (tap_state == 4'h0 && $past(tap_state) == 4'h0 |->
        cur_instr == jtc_pkg::OP_IDCODE && bsr_update == '0) else $error("reset state not clean");
    a_test_mode: assert property (test_mode == (cur_instr == jtc_pkg::OP_EXTEST && tap_state != 4'h0))
        else $error("test mode wrong");
    a_selftest_idle: assert property (selftest_run == (tap_state == 4'h1 && cur_instr == jtc_pkg::OP_SELFTEST))
        else $error("self test wrong");
    a_instr_update: assert property ($changed(cur_instr) |-> tap_state == 4'hf || tap_state == 4'h0)
        else $error("instruction changed outside update");
    a_bsr_update: assert property ($changed(bsr_update) |-> tap_state == 4'h8 || tap_state == 4'h0)
        else $error("boundary latch changed outside update");
endmodule
bind jtc_tap jtc_tap_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .test_mode(test_mode), .selftest_run(selftest_run), .bsr_update(bsr_update), .cur_instr(cur_instr),
    .tap_state(tap_state));

// *** bench/jtc_master.sv ***
`timescale 1ns/1ns
module jtc_master (
    input wire logic ref_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [3:0] tap_state,
    output logic tck,
    output logic tms,
    output logic tdi
);
    logic last;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        last = 1'b0;
    end
    // One test clock of 8 system clocks; clock rests low between calls
    task automatic bit_cycle(input logic m, input logic d, output logic so, output logic oe, output logic [3:0] st);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge ref_clk);
        st = tap_state;
        @(posedge ref_clk);
        tck <= 1'b1;
        repeat (2) @(posedge ref_clk);
        oe = tdo_oe;
        // Undriven line reads back inverted so a stale level cannot pass
        so = tdo_oe ? tdo : ~last;
        last = so;
        repeat (2) @(posedge ref_clk);
        tck <= 1'b0;
    endtask
endmodule

// *** bench/jtc_tap_tb.sv ***
`timescale 1ns/1ns
module jtc_tap_tb;
    localparam logic [63:0] N0 = 64'h1bddbba146644311;
    localparam logic [63:0] N1 = 64'h2fefcc0287855920;
    logic ref_clk, reset_n, program_n, tck, tms, tdi, tdo, tdo_oe, test_mode, selftest_run, so, oe;
    logic [jtc_pkg::BSR_LEN-1:0] bsr_in, bsr_upd, bsr_m;
    logic [31:0] cfg_in, cfg_upd, dr_m, cfg_m;
    logic [9:0] cur_instr, ir_m, cur_m;
    logic [3:0] tap_state, st;
    logic [9:0] ops [7] = '{10'h3c0, 10'h3c1, 10'h3c9, 10'h3c5, 10'h3c7, 10'h3ff, 10'h155};
    int n_errors = 0, check_count = 0, st_m, len_m;
    jtc_tap u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .program_n(program_n),
        .bsr_pins_in(bsr_in), .cfg_status_in(cfg_in), .tdo(tdo), .tdo_oe(tdo_oe), .test_mode(test_mode),
        .selftest_run(selftest_run), .bsr_update(bsr_upd), .cfg_update(cfg_upd), .cur_instr(cur_instr),
        .tap_state(tap_state));
    jtc_master u_master (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tap_state(tap_state), .tck(tck),
        .tms(tms), .tdi(tdi));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic finish_test;
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic step(input logic m, input logic d);
        u_master.bit_cycle(m, d, so, oe, st);
        chk("tap_state", st_m, 32'(st));
        chk("tdo_oe", st_m == 4 || st_m == 11, 32'(oe));
        if (oe) chk("tdo", st_m == 11 ? ir_m[0] : dr_m[0], 32'(so));
        if (st_m != 15) chk("cur_instr", 32'(cur_m), 32'(cur_instr));
        if (st_m != 8) chk("bsr_update", 32'(bsr_m), 32'(bsr_upd));
        if (st_m != 8) chk("cfg_update", cfg_m, cfg_upd);
        case (st_m)
            3: begin
                len_m = 1;
                dr_m = '0;
                if (cur_m == jtc_pkg::OP_IDCODE || cur_m == jtc_pkg::OP_CFG) len_m = 32;
                if (cur_m == jtc_pkg::OP_IDCODE) dr_m = jtc_pkg::ID_VALUE;
                if (cur_m == jtc_pkg::OP_CFG) dr_m = cfg_in;
                if (cur_m == jtc_pkg::OP_EXTEST || cur_m == jtc_pkg::OP_SAMPLE) begin
                    len_m = jtc_pkg::BSR_LEN;
                    dr_m = 32'(bsr_in);
                end
            end
            4: begin
                dr_m = dr_m >> 1;
                dr_m[len_m-1] = d;
            end
            8: begin
                if (cur_m == jtc_pkg::OP_EXTEST || cur_m == jtc_pkg::OP_SAMPLE) bsr_m = dr_m[11:0];
                if (cur_m == jtc_pkg::OP_CFG) cfg_m = dr_m;
            end
            10: ir_m = jtc_pkg::IR_CAPTURE;
            11: ir_m = {d, ir_m[9:1]};
            15: cur_m = ir_m;
            default: ;
        endcase
        st_m = m ? N1[4*st_m+:4] : N0[4*st_m+:4];
        if (st_m == 0) begin
            cur_m = jtc_pkg::OP_IDCODE;
            bsr_m = '0;
        end
    endtask
    task automatic go(input logic [31:0] ms, input int n, input logic [31:0] ds);
        for (int i = 0; i < n; i++) step(ms[i], ds[i]);
    endtask
    task automatic model_reset;
        st_m = 0;
        cur_m = jtc_pkg::OP_IDCODE;
        bsr_m = '0;
        cfg_m = '0;
    endtask
    initial begin
        reset_n = 1'b0;
        program_n = 1'b1;
        bsr_in = '0;
        cfg_in = '0;
        ir_m = '0;
        dr_m = '0;
        len_m = 1;
        model_reset();
        void'($urandom(32'h85ade4c1));
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        go('1, 6, '1);
        step(1'b0, 1'b1);
        foreach (ops[k]) begin
            bsr_in <= 12'($urandom);
            cfg_in <= $urandom;
            program_n <= 1'($urandom);
            go(32'h6003, 16, {2'b11, ops[k], 4'hf});
            // Idle state lands on the closing edge; look one clock later
            @(posedge ref_clk);
            chk("selftest_run", ops[k] == jtc_pkg::OP_SELFTEST, 32'(selftest_run));
            // Self test data path is not defined, so it is not scanned
            if (ops[k] != jtc_pkg::OP_SELFTEST) begin
                go(32'h1, 3, '1);
                for (int i = 0; i < 32; i++) step(i == 31, 1'($urandom));
                go(32'h1, 2, '1);
            end
        end
        repeat (1500) step(1'($urandom), 1'($urandom));
        go('1, 5, '1);
        step(1'b0, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        model_reset();
        repeat (4) @(posedge ref_clk);
        repeat (300) step(1'($urandom), 1'($urandom));
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end
endmodule
